// File: rtl/ssp_defs.svh
// register map, field positions, reset values and timing figures of the second serial port
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

// ----------------------------------------------------------------
// special-function register addresses
// ----------------------------------------------------------------
`define SSP_ADDR_CTRL      8'hC0
`define SSP_ADDR_DATA      8'hC1
`define SSP_RESET_BYTE     8'h00

// ----------------------------------------------------------------
// serial_two_control field positions
// ----------------------------------------------------------------
`define SSP_BIT_SM0        7
`define SSP_BIT_SM1        6
`define SSP_BIT_SM2        5
`define SSP_BIT_REN        4
`define SSP_BIT_TB8        3
`define SSP_BIT_RB8        2
`define SSP_BIT_TI         1
`define SSP_BIT_RI         0

// ----------------------------------------------------------------
// bit periods in peripheral clock periods
// ----------------------------------------------------------------
`define SSP_M0_SLOW_PCLK   12
`define SSP_M0_FAST_PCLK   4
`define SSP_M2_SLOW_PCLK   64
`define SSP_M2_FAST_PCLK   32
`define SSP_OVERSAMPLE     16

// ----------------------------------------------------------------
// frame shape and receive sampling points
// ----------------------------------------------------------------
`define SSP_DATA_BITS      8
`define SSP_M1_FRAME_BITS  10
`define SSP_M23_FRAME_BITS 11
`define SSP_VOTE_FIRST     7
`define SSP_VOTE_LAST      9
`define SSP_BUF_DEPTH      2

`endif

// File: rtl/ssp_pkg.sv
// types shared by the second serial port design files
package ssp_pkg;

  // ----------------------------------------------------------------
  // mode and state encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSP_MODE_SYNC = 2'h0,
    SSP_MODE_ONE  = 2'h1,
    SSP_MODE_TWO  = 2'h2,
    SSP_MODE_THR  = 2'h3
  } ssp_mode_t;

  typedef enum logic [2:0] {
    SSP_TX_IDLE  = 3'h1,
    SSP_TX_ASYNC = 3'h2,
    SSP_TX_SYNC  = 3'h4
  } ssp_tx_state_t;

  typedef enum logic [1:0] {
    SSP_RX_IDLE = 2'h1,
    SSP_RX_BUSY = 2'h2
  } ssp_rx_state_t;

  // ----------------------------------------------------------------
  // state of the port apart from the receive word buffer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]    ctrl;
    logic [7:0]    txBuf;
    logic [7:0]    rxBuf;
    logic [7:0]    rdData;
    logic [3:0]    preCnt;
    logic          t1Half;
    logic          sampTick;
    ssp_tx_state_t txState;
    logic [10:0]   txShift;
    logic [3:0]    txBits;
    logic [3:0]    txPhase;
    logic          syncRx;
    logic [7:0]    syncShift;
    logic          txdOut;
    logic          rxdOut;
    logic          rxdOe;
    ssp_rx_state_t rxState;
    logic [3:0]    rxPhase;
    logic [3:0]    rxBits;
    logic [7:0]    rxShift;
    logic [1:0]    votes;
    logic          rxdPrev;
    logic          pushValid;
    logic [9:0]    pushData;
  } ssp_state_t;

endpackage : ssp_pkg

// File: rtl/ssp_rx_buf2.sv
// small valid/ready buffer holding received words until software takes them
`timescale 1ns/1ps
`include "ssp_defs.svh"

module ssp_rx_buf2 #(
  parameter int W     = 10,
  parameter int DEPTH = `SSP_BUF_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wrPtr;
    logic [PW-1:0]           rdPtr;
    logic [CW-1:0]           count;
  } ssp_buf_state_t;

  ssp_buf_state_t r;
  ssp_buf_state_t n;
  logic           doPush;
  logic           doPop;

  assign inReady  = (r.count != FULL_CNT);
  assign outValid = (r.count != '0);
  // read data come straight from the storage register
  assign outData  = r.mem[r.rdPtr];

  always_comb begin
    n      = r;
    doPush = inValid && inReady;
    doPop  = outValid && outReady;
    if (doPush) begin
      n.mem[r.wrPtr] = inData;
      n.wrPtr        = (r.wrPtr == LAST_PTR) ? '0 : PW'(r.wrPtr + 1'b1);
    end
    if (doPop) begin
      n.rdPtr = (r.rdPtr == LAST_PTR) ? '0 : PW'(r.rdPtr + 1'b1);
    end
    if (doPush && !doPop) begin
      n.count = CW'(r.count + 1'b1);
    end else if (doPop && !doPush) begin
      n.count = CW'(r.count - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

endmodule : ssp_rx_buf2

// File: rtl/ssp_usart.sv
// second serial port: synchronous shift mode and three asynchronous frame modes
`timescale 1ns/1ps
`include "ssp_defs.svh"

module ssp_usart
  import ssp_pkg::*;
#(
  parameter int BUF_DEPTH = `SSP_BUF_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfrAddr,
  input  wire logic [7:0] sfrWrData,
  input  wire logic       sfrWr,
  input  wire logic       sfrRd,
  output logic [7:0]      sfrRdData,
  input  wire logic       idleMode,
  input  wire logic       baudDoubling,
  input  wire logic       t1Overflow,
  input  wire logic       rxdIn,
  output logic            rxdOut,
  output logic            rxdOe,
  output logic            txdOut,
  output logic            txCompleteFlag,
  output logic            rxCompleteFlag
);

  // ----------------------------------------------------------------
  // derived timing counts
  // ----------------------------------------------------------------
  // sync mode ticks on each half bit so the shift clock has two phases
  localparam logic [3:0] M0_SLOW_HALF = 4'(`SSP_M0_SLOW_PCLK / 2);
  localparam logic [3:0] M0_FAST_HALF = 4'(`SSP_M0_FAST_PCLK / 2);
  localparam logic [3:0] M2_SLOW_TICK = 4'(`SSP_M2_SLOW_PCLK / `SSP_OVERSAMPLE);
  localparam logic [3:0] M2_FAST_TICK = 4'(`SSP_M2_FAST_PCLK / `SSP_OVERSAMPLE);
  localparam logic [3:0] PHASE_LAST   = 4'(`SSP_OVERSAMPLE - 1);
  localparam logic [3:0] VOTE_FIRST   = 4'(`SSP_VOTE_FIRST);
  localparam logic [3:0] VOTE_LAST    = 4'(`SSP_VOTE_LAST);
  localparam logic [3:0] SYNC_LAST    = 4'(`SSP_DATA_BITS - 1);
  localparam logic [3:0] NINTH_IDX    = 4'(`SSP_DATA_BITS + 1);
  localparam logic [3:0] STOP23_IDX   = 4'(`SSP_DATA_BITS + 2);
  localparam logic [3:0] M1_LAST      = 4'(`SSP_M1_FRAME_BITS - 1);
  localparam logic [3:0] M23_LAST     = 4'(`SSP_M23_FRAME_BITS - 1);

  // ----------------------------------------------------------------
  // state and combinational helpers
  // ----------------------------------------------------------------
  ssp_state_t r;
  ssp_state_t n;

  ssp_mode_t  mode;
  ssp_mode_t  newMode;
  logic       smThird;
  logic [3:0] tickLimit;
  logic [3:0] lastTxData;
  logic [3:0] lastTxBit;
  logic       wrCtrl;
  logic       wrData;
  logic       startTx;
  logic       startSyncRx;
  logic       tiSet;
  logic       riSet;
  logic       bitVal;
  logic       bufInReady;
  logic       bufOutValid;
  logic       bufOutReady;
  logic [9:0] bufOutData;

  // ----------------------------------------------------------------
  // receive word buffer
  // ----------------------------------------------------------------
  // a word waits here while the receive flag is still set, so a late
  // software clear costs no frame while the buffer has room
  // flag blocks drain
  assign bufOutReady = !r.ctrl[`SSP_BIT_RI];

  ssp_rx_buf2 #(
    .W     (10),
    .DEPTH (BUF_DEPTH)
  ) u_rx_buf (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (r.pushValid),
    .inData   (r.pushData),
    .inReady  (bufInReady),
    .outValid (bufOutValid),
    .outReady (bufOutReady),
    .outData  (bufOutData)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n           = r;
    n.sampTick  = 1'b0;
    n.pushValid = 1'b0;
    n.rxdPrev   = rxdIn;
    tiSet       = 1'b0;
    riSet       = 1'b0;
    bitVal      = 1'b0;
    mode        = ssp_mode_t'({r.ctrl[`SSP_BIT_SM0], r.ctrl[`SSP_BIT_SM1]});
    newMode     = ssp_mode_t'({sfrWrData[`SSP_BIT_SM0], sfrWrData[`SSP_BIT_SM1]});
    smThird     = r.ctrl[`SSP_BIT_SM2];
    wrCtrl      = sfrWr && (sfrAddr == `SSP_ADDR_CTRL);
    wrData      = sfrWr && (sfrAddr == `SSP_ADDR_DATA);

    if (mode == SSP_MODE_SYNC) begin
      tickLimit = smThird ? M0_FAST_HALF : M0_SLOW_HALF;
    end else begin
      tickLimit = baudDoubling ? M2_FAST_TICK : M2_SLOW_TICK;
    end
    lastTxData = (mode == SSP_MODE_ONE) ? 4'(`SSP_DATA_BITS) : NINTH_IDX;
    lastTxBit  = (mode == SSP_MODE_ONE) ? M1_LAST : M23_LAST;

    // --------------------------------------------------------------
    // sample tick prescaler
    // --------------------------------------------------------------
    // idle freezes timing
    if (!idleMode) begin
      if (mode == SSP_MODE_ONE || mode == SSP_MODE_THR) begin
        n.preCnt = '0;
        if (t1Overflow) begin
          n.t1Half   = ~r.t1Half;
          n.sampTick = baudDoubling | r.t1Half;
        end
      end else if (r.preCnt >= 4'(tickLimit - 4'h1)) begin
        n.preCnt   = '0;
        n.sampTick = 1'b1;
      end else begin
        n.preCnt = 4'(r.preCnt + 4'h1);
      end
    end

    // --------------------------------------------------------------
    // register access
    // --------------------------------------------------------------
    if (wrCtrl) begin
      n.ctrl = sfrWrData;
    end
    if (wrData) begin
      n.txBuf = sfrWrData;
    end
    if (sfrRd) begin
      if (sfrAddr == `SSP_ADDR_CTRL) begin
        n.rdData = r.ctrl;
      end else if (sfrAddr == `SSP_ADDR_DATA) begin
        n.rdData = r.rxBuf;
      end else begin
        n.rdData = `SSP_RESET_BYTE;
      end
    end

    startTx     = wrData && (r.txState == SSP_TX_IDLE);
    startSyncRx = wrCtrl && (newMode == SSP_MODE_SYNC) && sfrWrData[`SSP_BIT_REN]
                  && !r.ctrl[`SSP_BIT_REN] && (r.txState == SSP_TX_IDLE) && bufInReady;

    // --------------------------------------------------------------
    // transmitter and synchronous shifter
    // --------------------------------------------------------------
    unique case (r.txState)
      SSP_TX_IDLE: begin
        if (startTx) begin
          n.txBits  = '0;
          n.txPhase = '0;
          if (mode == SSP_MODE_SYNC) begin
            n.txState   = SSP_TX_SYNC;
            n.syncRx    = 1'b0;
            n.syncShift = sfrWrData;
            n.rxdOut    = sfrWrData[0];
            n.rxdOe     = 1'b1;
          end else begin
            n.txState = SSP_TX_ASYNC;
            // start bit waits for the next tick so it lasts a whole bit period
            n.txBits  = '1;
            n.txPhase = PHASE_LAST;
            n.txShift = {(mode == SSP_MODE_ONE) ? 1'b1 : r.ctrl[`SSP_BIT_TB8],
                         sfrWrData, 1'b0, 1'b1};
          end
        end else if (startSyncRx) begin
          n.txState   = SSP_TX_SYNC;
          n.syncRx    = 1'b1;
          n.syncShift = '0;
          n.txBits    = '0;
          n.txPhase   = '0;
          n.rxdOe     = 1'b0;
        end
      end
      SSP_TX_ASYNC: begin
        if (r.sampTick) begin
          n.txPhase = 4'(r.txPhase + 4'h1);
          if (r.txPhase == PHASE_LAST) begin
            n.txShift = {1'b1, r.txShift[10:1]};
            n.txdOut  = r.txShift[1];
            n.txBits  = 4'(r.txBits + 4'h1);
            if (r.txBits == lastTxData) begin
              tiSet = 1'b1;
            end
            if (r.txBits == lastTxBit) begin
              n.txState = SSP_TX_IDLE;
              n.txdOut  = 1'b1;
            end
          end
        end
      end
      SSP_TX_SYNC: begin
        if (r.sampTick) begin
          if (!r.txPhase[0]) begin
            n.txdOut  = 1'b0;
            n.txPhase = 4'h1;
          end else begin
            n.txdOut  = 1'b1;
            n.txPhase = 4'h0;
            n.txBits  = 4'(r.txBits + 4'h1);
            // received bits are taken on the rising shift clock
            if (r.syncRx) begin
              n.syncShift = {rxdIn, r.syncShift[7:1]};
            end else begin
              n.syncShift = {1'b0, r.syncShift[7:1]};
              n.rxdOut    = r.syncShift[1];
            end
            if (r.txBits == SYNC_LAST) begin
              n.txState = SSP_TX_IDLE;
              n.rxdOe   = 1'b0;
              n.rxdOut  = 1'b1;
              if (r.syncRx) begin
                // ninth bit untouched in mode 0
                n.pushValid = 1'b1;
                n.pushData  = {1'b0, 1'b0, rxdIn, r.syncShift[7:1]};
              end else begin
                tiSet = 1'b1;
              end
            end
          end
        end
      end
      default: begin
        n.txState = SSP_TX_IDLE;
        n.rxdOe   = 1'b0;
        n.txdOut  = 1'b1;
      end
    endcase

    // --------------------------------------------------------------
    // asynchronous receiver
    // --------------------------------------------------------------
    unique case (r.rxState)
      SSP_RX_IDLE: begin
        // enable gates reception
        // a start is not taken while the buffer cannot hold a word
        if (r.ctrl[`SSP_BIT_REN] && (mode != SSP_MODE_SYNC) && bufInReady
            && !r.pushValid && r.rxdPrev && !rxdIn) begin
          n.rxState = SSP_RX_BUSY;
          n.rxPhase = '0;
          n.rxBits  = '0;
          n.votes   = '0;
        end
      end
      SSP_RX_BUSY: begin
        if (!r.ctrl[`SSP_BIT_REN] || mode == SSP_MODE_SYNC) begin
          n.rxState = SSP_RX_IDLE;
        end else if (r.sampTick) begin
          n.rxPhase = 4'(r.rxPhase + 4'h1);
          if (r.rxPhase >= VOTE_FIRST && r.rxPhase < VOTE_LAST) begin
            n.votes = {r.votes[0], rxdIn};
          end
          if (r.rxPhase == VOTE_LAST) begin
            // two of three samples decide the bit
            bitVal = (r.votes[1] & r.votes[0]) | (r.votes[1] & rxdIn)
                     | (r.votes[0] & rxdIn);
            if (r.rxBits == '0) begin
              if (bitVal) begin
                n.rxState = SSP_RX_IDLE;
              end
            end else if (r.rxBits == NINTH_IDX) begin
              if (!smThird || bitVal) begin
                n.pushValid = 1'b1;
                n.pushData  = {1'b1, bitVal, r.rxShift};
              end
              if (mode == SSP_MODE_ONE) begin
                n.rxState = SSP_RX_IDLE;
              end
            end else if (r.rxBits == STOP23_IDX) begin
              n.rxState = SSP_RX_IDLE;
            end else begin
              n.rxShift = {bitVal, r.rxShift[7:1]};
            end
          end
          if (r.rxPhase == PHASE_LAST) begin
            n.rxBits = 4'(r.rxBits + 4'h1);
          end
        end
      end
      default: begin
        n.rxState = SSP_RX_IDLE;
      end
    endcase

    // --------------------------------------------------------------
    // hand received words to software
    // --------------------------------------------------------------
    if (bufOutValid && bufOutReady) begin
      n.rxBuf = bufOutData[7:0];
      if (bufOutData[9]) begin
        n.ctrl[`SSP_BIT_RB8] = bufOutData[8];
      end
      riSet = 1'b1;
    end

    // hardware sets win over a software clear in the same cycle
    // hardware only sets
    if (tiSet) begin
      n.ctrl[`SSP_BIT_TI] = 1'b1;
    end
    if (riSet) begin
      n.ctrl[`SSP_BIT_RI] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r           <= '0;
      r.txState   <= SSP_TX_IDLE;
      r.rxState   <= SSP_RX_IDLE;
      r.txShift   <= '1;
      r.txdOut    <= 1'b1;
      r.rxdOut    <= 1'b1;
      r.rxdPrev   <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sfrRdData      = r.rdData;
  assign rxdOut         = r.rxdOut;
  assign rxdOe          = r.rxdOe;
  assign txdOut         = r.txdOut;
  assign txCompleteFlag = r.ctrl[`SSP_BIT_TI];
  assign rxCompleteFlag = r.ctrl[`SSP_BIT_RI];

endmodule : ssp_usart

// File: sim/ssp_peer.sv
// serial peer: async frame sender and mode 0 shift partner
`timescale 1ns/1ps

module ssp_peer (
  input  wire logic clk,
  input  wire logic txdOut,
  input  wire logic rxdOut,
  input  wire logic rxdOe,
  output logic      rxdIn
);
  logic [7:0] cap;
  logic [7:0] m0Byte;
  logic       m0Rx;

  initial begin
    rxdIn = 1'b1;
    cap = 8'h00;
    m0Byte = 8'h00;
    m0Rx = 1'b0;
  end

  // data is stable while the shift clock is low, so both sides move on its fall
  always @(negedge txdOut) begin
    if (rxdOe)
      cap = {rxdOut, cap[7:1]};
    if (m0Rx) begin
      rxdIn = m0Byte[0];
      m0Byte = {1'b1, m0Byte[7:1]};
    end
  end

  // bit 0 of f goes first; the line is left high after the frame
  task automatic sendFrame(input logic [10:0] f, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      rxdIn = f[i];
      repeat (per) @(negedge clk);
    end
    rxdIn = 1'b1;
  endtask : sendFrame
endmodule : ssp_peer

// File: sim/ssp_usart_asserts.sv
// concurrent checks on the second serial port pins and register reads
`timescale 1ns/1ps
`include "ssp_defs.svh"

module ssp_usart_asserts (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic       sfrWr,
  input wire logic       sfrRd,
  input wire logic [7:0] sfrRdData,
  input wire logic       idleMode,
  input wire logic       baudDoubling,
  input wire logic       rxdOut,
  input wire logic       rxdOe,
  input wire logic       txdOut
);
  logic [2:0] modeSh_reg;
  logic [9:0] lowLen_reg;
  logic       wrCtl;

  assign wrCtl = sfrWr && sfrAddr == `SSP_ADDR_CTRL;

  // mode bits as last written; hardware never changes them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modeSh_reg <= 3'h0;
      lowLen_reg <= 10'h000;
    end else begin
      if (wrCtl)
        modeSh_reg <= sfrWrData[7:5];
      lowLen_reg <= txdOut ? 10'h000 : lowLen_reg + 10'h001;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_lowSlow;
    (!txdOut)[*6] ##1 txdOut;
  endsequence
  sequence s_lowFast;
    (!txdOut)[*2] ##1 txdOut;
  endsequence

  chk_rd_unmapped: assert property (
    sfrRd && sfrAddr != `SSP_ADDR_CTRL && sfrAddr != `SSP_ADDR_DATA |=> sfrRdData == 8'h00)
    else $error("unmapped read not zero");
  chk_oe_mode_zero: assert property (rxdOe |-> modeSh_reg[2:1] == 2'h0)
    else $error("data pin driven outside mode 0");
  chk_line_idle_high: assert property (!rxdOe |-> rxdOut)
    else $error("data pin output not idle high");
  chk_idle_freeze: assert property (
    idleMode && $past(idleMode) && $past(idleMode, 2) && !$past(sfrWr) && !$past(sfrWr, 2)
    |-> $stable(txdOut) && $stable(rxdOe))
    else $error("serial timing moved in idle");
  chk_m0_slow_clk: assert property (
    $fell(txdOut) && modeSh_reg == 3'h0 && !idleMode |-> s_lowSlow)
    else $error("slow shift clock low phase wrong");
  chk_m0_fast_clk: assert property (
    $fell(txdOut) && modeSh_reg == 3'h1 && !idleMode |-> s_lowFast)
    else $error("fast shift clock low phase wrong");
  chk_async_bit_len: assert property (
    $rose(txdOut) && modeSh_reg[2:1] == 2'h2 && !idleMode
    |-> lowLen_reg[4:0] == 5'h00 && (baudDoubling || !lowLen_reg[5]))
    else $error("mode 2 bit period wrong");
endmodule : ssp_usart_asserts

bind ssp_usart ssp_usart_asserts i_chk (
  .clk(clk), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWr(sfrWr),
  .sfrRd(sfrRd), .sfrRdData(sfrRdData), .idleMode(idleMode), .baudDoubling(baudDoubling),
  .rxdOut(rxdOut), .rxdOe(rxdOe), .txdOut(txdOut)
);

// File: sim/tb.sv
// self-checking bench of the second serial port
`timescale 1ns/1ps
`include "ssp_defs.svh"

module tb;
  logic        clk, rst_n, sfrWr, sfrRd, idleMode, baudDoubling, t1Overflow;
  logic [7:0]  sfrAddr, sfrWrData, sfrRdData, d, c;
  logic        rxdIn, rxdOut, rxdOe, txdOut, txCompleteFlag, rxCompleteFlag, b9;
  logic [10:0] f;
  int          errors, samples_checked, cycles, n, per, w;

  ssp_usart i_dut (.clk(clk), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
    .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdData(sfrRdData), .idleMode(idleMode),
    .baudDoubling(baudDoubling), .t1Overflow(t1Overflow), .rxdIn(rxdIn), .rxdOut(rxdOut),
    .rxdOe(rxdOe), .txdOut(txdOut), .txCompleteFlag(txCompleteFlag),
    .rxCompleteFlag(rxCompleteFlag));
  ssp_peer i_peer (.clk(clk), .txdOut(txdOut), .rxdOut(rxdOut), .rxdOe(rxdOe), .rxdIn(rxdIn));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // overflow pulse every second clock gives 32-clock bits with doubling on
  always @(negedge clk) t1Overflow <= ~t1Overflow;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    if (errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    sfrAddr = a;
    sfrWrData = v;
    sfrWr = 1'b1;
    @(negedge clk);
    sfrWr = 1'b0;
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    sfrAddr = a;
    sfrRd = 1'b1;
    @(negedge clk);
    sfrRd = 1'b0;
    check(sfrRdData, e);
  endtask : rdChk

  // bounded wait for a flag; a miss shows in the following compare
  task automatic waitFlag(input bit ri);
    for (int i = 0; i < 3000 && (ri ? rxCompleteFlag : txCompleteFlag) !== 1'b1; i++)
      @(negedge clk);
  endtask : waitFlag

  initial begin
    {rst_n, sfrWr, sfrRd, idleMode, t1Overflow, sfrAddr, sfrWrData} = '0;
    baudDoubling = 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    rdChk(`SSP_ADDR_CTRL, 8'h00);
    rdChk(`SSP_ADDR_DATA, 8'h00);
    rdChk(8'hC2, 8'h00);
    // -------------------------------------------------------------
    // shift mode: transmit at both rates, then one receive
    // -------------------------------------------------------------
    for (int k = 0; k < 2; k++) begin
      d = k ? 8'hA5 : 8'h5A;
      wr(`SSP_ADDR_CTRL, k ? 8'h20 : 8'h00);
      wr(`SSP_ADDR_DATA, d);
      rdChk(`SSP_ADDR_DATA, 8'h00);
      check(8'(txCompleteFlag), 8'h00);
      waitFlag(0);
      check(i_peer.cap, d);
      check(8'(txCompleteFlag), 8'h01);
    end
    wr(`SSP_ADDR_CTRL, 8'h00);
    i_peer.m0Byte = 8'hC3;
    i_peer.m0Rx = 1'b1;
    wr(`SSP_ADDR_CTRL, 8'h10);
    waitFlag(1);
    i_peer.m0Rx = 1'b0;
    rdChk(`SSP_ADDR_DATA, 8'hC3);
    // -------------------------------------------------------------
    // async transmit in modes 1, 2 (both rates) and 3
    // -------------------------------------------------------------
    for (int k = 0; k < 4; k++) begin
      c = {k == 0 ? 2'h1 : k == 3 ? 2'h3 : 2'h2, 2'h0, k[0], 3'h0};
      baudDoubling = k[0];
      n = k == 0 ? 10 : 11;
      per = k[0] ? 32 : 64;
      d = 8'(8'h6C + k);
      f = {1'b1, k == 0 ? 1'b1 : k[0], d, 1'b0};
      wr(`SSP_ADDR_CTRL, c);
      wr(`SSP_ADDR_DATA, d);
      for (w = 0; txdOut !== 1'b0 && w < 200; w++)
        @(negedge clk);
      repeat (per / 2) @(negedge clk);
      for (int i = 0; i < n; i++) begin
        check(8'(txdOut), 8'(f[i]));
        if (i >= n - 2)
          check(8'(txCompleteFlag), 8'(i == n - 1));
        repeat (per) @(negedge clk);
      end
    end
    // -------------------------------------------------------------
    // async receive in modes 1 to 3
    // -------------------------------------------------------------
    for (int k = 1; k < 4; k++) begin
      b9 = k != 3;
      d = 8'(8'h30 + k);
      wr(`SSP_ADDR_CTRL, {k[1:0], 6'h10});
      i_peer.sendFrame({1'b1, b9, d, 1'b0}, k == 1 ? 10 : 11, 32);
      waitFlag(1);
      rdChk(`SSP_ADDR_DATA, d);
      rdChk(`SSP_ADDR_CTRL, {k[1:0], 3'h2, b9, 2'h1});
    end
    // bad stop, address filter, reception off, then an accepted address
    for (int k = 0; k < 4; k++) begin
      wr(`SSP_ADDR_CTRL, k == 0 ? 8'h70 : k == 2 ? 8'h80 : 8'hB0);
      i_peer.sendFrame({1'b1, k == 3, 8'h66, 1'b0}, k == 0 ? 10 : 11, 32);
      repeat (64) @(negedge clk);
      check(8'(rxCompleteFlag), 8'(k == 3));
    end
    // -------------------------------------------------------------
    // receive buffer: fill past capacity while software stalls
    // -------------------------------------------------------------
    wr(`SSP_ADDR_CTRL, 8'h90);
    for (int k = 0; k < 4; k++)
      i_peer.sendFrame({2'h3, 8'(8'h40 + k), 1'b0}, 11, 32);
    for (int k = 0; k < 3; k++) begin
      check(8'(rxCompleteFlag), 8'h01);
      rdChk(`SSP_ADDR_DATA, 8'(8'h40 + k));
      wr(`SSP_ADDR_CTRL, 8'h90);
      repeat (4) @(negedge clk);
    end
    check(8'(rxCompleteFlag), 8'h00);
    // -------------------------------------------------------------
    // idle freezes a mode 3 transmit until released
    // -------------------------------------------------------------
    wr(`SSP_ADDR_CTRL, 8'hC0);
    wr(`SSP_ADDR_DATA, 8'h99);
    idleMode = 1'b1;
    repeat (400) @(negedge clk);
    check(8'(txCompleteFlag), 8'h00);
    idleMode = 1'b0;
    waitFlag(0);
    check(8'(txCompleteFlag), 8'h01);
    test_done();
  end
endmodule : tb
